// file: src/idx_top.sv
// Notes on behaviour
// - Buffer enable is an active-low flop output wired straight to the transceiver.
// - Buffer enable asserts only for a decoded peripheral whose select is enabled.
// - Buffer enable starts at the falling edge of any ISA command.
// - Released at command rise for PCI-master cycles, at address change for ISA master.
// - No buffer enable for a peripheral whose decode range is disabled.
// - Buffer enable pin may become a general output by configuration.
// - Buffer enable and both grant groups are high in reset and suspend; general outputs follow value in suspend.
// - Request and grant lines exist for channels 0-3 and 5-7, not 4.
// - A grant means DMA service granted or a 16-bit master owns the bus.
// - Request and grant polarity are programmable in the command register.
// - A request that drops before being granted never gets a grant.
// - Request activation is treated as asynchronous to the clock.
// - PCI agents request on three active-low lines; unused they are general inputs.
// - PCI-side grants are three active-low outputs, reassignable as general outputs.
// - Terminal count asserts after a new address when the byte count expires.
// - Outside autoinitialization, terminal count holds until address enable falls.
// - During autoinitialization, terminal count drops before address enable does.
// - Terminal count is low in reset, after reset and in suspend.
`timescale 1ns/1ps
`include "idx_params.svh"

module idx_top
    import idx_pkg::*;
(
    // Clock, reset and suspend
    input  wire logic                      ref_clk_i,
    input  wire logic                      rst_i,
    input  wire logic                      pos_i,
    // APB slave
    input  wire logic                      psel_i,
    input  wire logic                      penable_i,
    input  wire logic                      pwrite_i,
    input  wire logic [`IDX_ADDR_W-1:0]    paddr_i,
    input  wire logic [31:0]               pwdata_i,
    output logic      [31:0]               prdata_o,
    output logic                           pready_o,
    output logic                           pslverr_o,
    // ISA pins
    input  wire logic [`IDX_NCMD-1:0]      isa_cmd_n_i,
    input  wire logic [`IDX_SA_W-1:0]      isa_sa_i,
    input  wire logic [`IDX_LA_W-1:0]      isa_la_i,
    input  wire logic [`IDX_NCH-1:0]       dma_request_line_i,
    output logic      [`IDX_NCH-1:0]       dma_grant_line_o,
    output logic                           xbus_buffer_output_enable_n_o,
    output logic                           terminal_count_output_o,
    // PCI-side DMA pins
    input  wire logic [`IDX_NPC-1:0]       pc_req_n_i,
    output logic      [`IDX_NPC-1:0]       pc_gnt_n_o,
    // Internal decode and DMA controller status
    input  wire logic [`IDX_CSEN_MSB:0]    xbus_decode_i,
    input  wire logic                      isa_master_cycle_i,
    input  wire logic                      addr_out_i,
    input  wire logic                      count_expired_i,
    input  wire logic                      aen_i,
    input  wire logic                      autoinit_i
);

    localparam int SYNW = `IDX_NCMD + `IDX_SA_W + `IDX_LA_W + `IDX_NCH + `IDX_NPC;

    logic [31:0]               ctrl_q;
    logic [31:0]               csen_q;
    logic [31:0]               prdata_q;
    logic                      pready_q;
    logic                      pslverr_q;
    logic [SYNW-1:0]           sync1_q;
    logic [SYNW-1:0]           sync2_q;
    logic [SYNW-1:0]           sync3_q;
    idx_arb_t                  arb_q;
    idx_arb_t                  arb_d;
    logic [`IDX_NCH-1:0]       grant_q;
    logic [`IDX_NCH-1:0]       grant_d;
    idx_xoe_t                  xoe_q;
    idx_xoe_t                  xoe_d;
    logic                      xoe_isa_q;
    logic                      tc_q;
    logic                      tc_d;
    logic [`IDX_NPC-1:0]       pcg_q;
    logic [`IDX_NCH-1:0]       dma_grant_line_q;
    logic                      xoe_n_q;
    logic [`IDX_NPC-1:0]       pcgn_q;

    // Pin inputs; only the second and third stages are ever read.
    wire [SYNW-1:0] pins = {isa_cmd_n_i, isa_sa_i, isa_la_i, dma_request_line_i, pc_req_n_i};

    always_ff @(posedge ref_clk_i) begin
        sync1_q <= pins;
        sync2_q <= sync1_q;
        sync3_q <= sync2_q;
    end

    wire [`IDX_NPC-1:0]  pcreq_n_s = sync2_q[`IDX_NPC-1:0];
    wire [`IDX_NCH-1:0]  dma_request_line_s    = sync2_q[`IDX_NPC +: `IDX_NCH];
    wire [23:0]          addr_s    = sync2_q[`IDX_NPC + `IDX_NCH +: 24];
    wire [23:0]          addr_p    = sync3_q[`IDX_NPC + `IDX_NCH +: 24];
    wire [`IDX_NCMD-1:0] cmd_s     = sync2_q[SYNW-1 -: `IDX_NCMD];
    wire [`IDX_NCMD-1:0] cmd_p     = sync3_q[SYNW-1 -: `IDX_NCMD];

    // APB decode.
    wire       acc     = psel_i & penable_i & pready_q;
    wire       hit_ctl = (paddr_i == `IDX_OFF_CTRL);
    wire       hit_cse = (paddr_i == `IDX_OFF_CSEN);
    wire       hit_st  = (paddr_i == `IDX_OFF_STAT);
    wire       hit_pc  = (paddr_i == `IDX_OFF_PCST);
    wire       mapped  = hit_ctl | hit_cse | hit_st | hit_pc;
    wire       wr_ctl  = acc & pwrite_i & hit_ctl;
    wire       wr_cse  = acc & pwrite_i & hit_cse;

    wire       rpol    = ctrl_q[`IDX_CTRL_RPOL];
    wire       gpol    = ctrl_q[`IDX_CTRL_GPOL];
    wire       xgpo_en = ctrl_q[`IDX_CTRL_XGPO_EN];
    wire       xgpo_v  = ctrl_q[`IDX_CTRL_XGPO_VAL];
    wire       pcgp_en = ctrl_q[`IDX_CTRL_PCGP_EN];
    wire [2:0] pcgpo_v = ctrl_q[`IDX_CTRL_PCGPO_MSB:`IDX_CTRL_PCGPO_LSB];

    wire [31:0] stat_w = ({24'h0, 1'b0, dma_request_line_s} << `IDX_STAT_REQ_LSB)
                       | ({24'h0, 1'b0, dma_grant_line_q} << `IDX_STAT_DMA_GRANT_LINE_LSB)
                       | ({31'h0, tc_q} << `IDX_STAT_TC)
                       | ({31'h0, ~xoe_n_q} << `IDX_STAT_XOE)
                       | ({31'h0, arb_q == IDX_ARB_GRANT} << `IDX_STAT_GRANT);
    wire [31:0] pcst_w = {26'h0, pcgn_q, pcreq_n_s};
    wire [31:0] rdata  = hit_ctl ? ctrl_q :
                         hit_cse ? csen_q :
                         hit_st  ? stat_w :
                         hit_pc  ? pcst_w : 32'h0000_0000;

    // One wait state: data and error are registered while ready rises.
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            pready_q  <= 1'b0;
            prdata_q  <= 32'h0000_0000;
            pslverr_q <= 1'b0;
        end else begin
            pready_q  <= psel_i & penable_i & ~pready_q;
            prdata_q  <= rdata;
            pslverr_q <= psel_i & penable_i & ~pready_q & ~mapped;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            ctrl_q <= `IDX_CTRL_RST;
            csen_q <= `IDX_CSEN_RST;
        end else begin
            if (wr_ctl) begin
                ctrl_q <= pwdata_i & 32'h0000_00FF;
            end
            if (wr_cse) begin
                csen_q <= pwdata_i & 32'h0000_003F;
            end
        end
    end

    // DMA arbitration: fixed priority, lowest index first, one grant at a time.
    wire [`IDX_NCH-1:0] req_act = rpol ? dma_request_line_s : ~dma_request_line_s;
    wire [`IDX_NCH-1:0] pick    = req_act & (~req_act + 7'h01);
    wire                held    = |(grant_q & req_act);

    always_comb begin
        arb_d   = arb_q;
        grant_d = grant_q;
        case (arb_q)
            IDX_ARB_IDLE: begin
                if (|req_act) begin
                    arb_d   = IDX_ARB_GRANT;
                    grant_d = pick;
                end
            end
            IDX_ARB_GRANT: begin
                if (!held) begin
                    arb_d   = IDX_ARB_IDLE;
                    grant_d = '0;
                end
            end
            default: begin
                arb_d   = IDX_ARB_IDLE;
                grant_d = '0;
            end
        endcase
    end

    // X-Bus buffer enable sequencing.
    wire dec_hit  = |(xbus_decode_i & csen_q[`IDX_CSEN_MSB:0]);
    wire cmd_fall = |(~cmd_s & cmd_p);
    wire cmd_rise = (&cmd_s) & ~(&cmd_p);
    wire addr_chg = (addr_s != addr_p);
    wire xoe_set  = cmd_fall & dec_hit;
    wire xoe_clr  = xoe_isa_q ? addr_chg : cmd_rise;

    always_comb begin
        xoe_d = xoe_q;
        case (xoe_q)
            IDX_XOE_IDLE: begin
                if (xoe_set) begin
                    xoe_d = IDX_XOE_ON;
                end
            end
            IDX_XOE_ON: begin
                if (xoe_clr) begin
                    xoe_d = IDX_XOE_IDLE;
                end
            end
            default: xoe_d = IDX_XOE_IDLE;
        endcase
    end

    // Terminal count: a new start wins over the clearing terms.
    wire tc_start = addr_out_i & count_expired_i;
    always_comb begin
        tc_d = tc_q;
        if (tc_start) begin
            tc_d = 1'b1;
        end else if (autoinit_i) begin
            tc_d = 1'b0;
        end else if (!aen_i) begin
            tc_d = 1'b0;
        end
    end

    // PCI-side grants: lowest active request wins and keeps it while held.
    wire [`IDX_NPC-1:0] pc_act  = ~pcreq_n_s;
    wire [`IDX_NPC-1:0] pc_pick = pc_act & (~pc_act + 3'h1);
    wire [`IDX_NPC-1:0] pcg_d   = |(pcg_q & pc_act) ? pcg_q : pc_pick;

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            arb_q     <= IDX_ARB_IDLE;
            grant_q   <= '0;
            xoe_q     <= IDX_XOE_IDLE;
            xoe_isa_q <= 1'b0;
            tc_q      <= 1'b0;
            pcg_q     <= '0;
        end else begin
            arb_q     <= arb_d;
            grant_q   <= grant_d;
            xoe_q     <= xoe_d;
            xoe_isa_q <= xoe_set ? isa_master_cycle_i : xoe_isa_q;
            tc_q      <= tc_d;
            pcg_q     <= pcgp_en ? '0 : pcg_d;
        end
    end

    // Pin drivers. Suspend parks grants high and TC low, so DMA grants are inactive only at active-low polarity; general outputs keep their value.
    wire [`IDX_NCH-1:0] dma_grant_line_w = gpol ? grant_q : ~grant_q;
    wire                xoe_w  = xgpo_en ? xgpo_v : ~(xoe_q == IDX_XOE_ON);
    wire [`IDX_NPC-1:0] pcgn_w = pcgp_en ? pcgpo_v : ~pcg_q;

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            dma_grant_line_q  <= '1;
            xoe_n_q <= 1'b1;
            pcgn_q  <= '1;
            terminal_count_output_o <= 1'b0;
        end else begin
            dma_grant_line_q  <= pos_i ? '1 : dma_grant_line_w;
            xoe_n_q <= (pos_i && !xgpo_en) ? 1'b1 : xoe_w;
            pcgn_q  <= (pos_i && !pcgp_en) ? '1 : pcgn_w;
            terminal_count_output_o <= pos_i ? 1'b0 : tc_d;
        end
    end

    assign prdata_o                      = prdata_q;
    assign pready_o                      = pready_q;
    assign pslverr_o                     = pslverr_q;
    assign dma_grant_line_o              = dma_grant_line_q;
    assign xbus_buffer_output_enable_n_o = xoe_n_q;
    assign pc_gnt_n_o                    = pcgn_q;

    // The slave decodes with its own grant; nothing here depends on that beyond
    // keeping the grant stable for the whole service.

    property p_xoe_cause;
        @(posedge ref_clk_i) disable iff (rst_i)
        $fell(xbus_buffer_output_enable_n_o) && !$past(xgpo_en) |-> $past(xoe_set, 2);
    endproperty
    a_xoe_cause: assert property (p_xoe_cause) else $error("enable fell without decode");

    property p_xoe_pci_rel;
        @(posedge ref_clk_i) disable iff (rst_i)
        xoe_q == IDX_XOE_ON && !xoe_isa_q && cmd_rise && !xgpo_en |=> ##1 xoe_n_q;
    endproperty
    a_xoe_pci_rel: assert property (p_xoe_pci_rel) else $error("enable held past command");

    property p_xoe_dis;
        @(posedge ref_clk_i) disable iff (rst_i)
        xoe_q == IDX_XOE_IDLE && !dec_hit |=> xoe_q == IDX_XOE_IDLE;
    endproperty
    a_xoe_dis: assert property (p_xoe_dis) else $error("enable for disabled decode");

    property p_xoe_gpo;
        @(posedge ref_clk_i) disable iff (rst_i)
        xgpo_en |=> xoe_n_q == $past(xgpo_v);
    endproperty
    a_xoe_gpo: assert property (p_xoe_gpo) else $error("general output wrong");

    property p_no_req_no_gnt;
        @(posedge ref_clk_i) disable iff (rst_i)
        arb_q == IDX_ARB_IDLE && !(|req_act) |=> grant_q == '0;
    endproperty
    a_no_req_no_gnt: assert property (p_no_req_no_gnt) else $error("grant w/o request");

    property p_dma_grant_line_pos;
        @(posedge ref_clk_i) disable iff (rst_i)
        pos_i |=> dma_grant_line_o == '1;
    endproperty
    a_dma_grant_line_pos: assert property (p_dma_grant_line_pos) else $error("grant active in suspend");

    property p_tc_set;
        @(posedge ref_clk_i) disable iff (rst_i)
        tc_start && !pos_i |=> terminal_count_output_o;
    endproperty
    a_tc_set: assert property (p_tc_set) else $error("terminal count missed");

    property p_tc_hold;
        @(posedge ref_clk_i) disable iff (rst_i)
        tc_q && aen_i && !autoinit_i && !pos_i |=> terminal_count_output_o;
    endproperty
    a_tc_hold: assert property (p_tc_hold) else $error("terminal count dropped early");

    property p_tc_auto;
        @(posedge ref_clk_i) disable iff (rst_i)
        autoinit_i && !tc_start |=> !terminal_count_output_o;
    endproperty
    a_tc_auto: assert property (p_tc_auto) else $error("terminal count in autoinit");

    property p_sync;
        @(posedge ref_clk_i) disable iff (rst_i)
        ##2 1'b1 |-> dma_request_line_s == $past(dma_request_line_i, 2);
    endproperty
    a_sync: assert property (p_sync) else $error("request sync depth wrong");

endmodule

// file: src/idx_params.svh
`ifndef IDX_PARAMS_SVH
`define IDX_PARAMS_SVH

`define IDX_ADDR_W         12
`define IDX_OFF_CTRL       12'h000
`define IDX_OFF_CSEN       12'h004
`define IDX_OFF_STAT       12'h008
`define IDX_OFF_PCST       12'h00C

`define IDX_CTRL_RPOL      0
`define IDX_CTRL_GPOL      1
`define IDX_CTRL_XGPO_EN   2
`define IDX_CTRL_XGPO_VAL  3
`define IDX_CTRL_PCGP_EN   4
`define IDX_CTRL_PCGPO_LSB 5
`define IDX_CTRL_PCGPO_MSB 7
`define IDX_CTRL_RST       32'h0000_00E8
`define IDX_CSEN_RST       32'h0000_0000
`define IDX_CSEN_MSB       5

`define IDX_NCH            7
`define IDX_NPC            3
`define IDX_NCMD           4
`define IDX_SA_W           17
`define IDX_LA_W           7

`define IDX_STAT_REQ_LSB   0
`define IDX_STAT_DMA_GRANT_LINE_LSB  8
`define IDX_STAT_TC        16
`define IDX_STAT_XOE       17
`define IDX_STAT_GRANT     18

`endif

// file: src/idx_pkg.sv
package idx_pkg;

    typedef enum logic [1:0] {
        IDX_ARB_IDLE  = 2'b01,
        IDX_ARB_GRANT = 2'b10
    } idx_arb_t;

    typedef enum logic [1:0] {
        IDX_XOE_IDLE = 2'b01,
        IDX_XOE_ON   = 2'b10
    } idx_xoe_t;

endpackage

// file: dv/idx_dma_slave.sv
`timescale 1ns/1ps

module idx_dma_slave (
    // Clock and reset
    input  wire logic       ref_clk_i,
    input  wire logic       rst_i,
    // Control from the bench
    input  wire logic       start_i,
    input  wire logic [2:0] ch_i,
    input  wire logic       req_pol_i,
    input  wire logic       gnt_pol_i,
    // Pins
    input  wire logic [6:0] gnt_i,
    output logic      [6:0] req_o
);
    logic act_q;

    // Only our own grant ends the request, so another channel's grant cannot free it.
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            act_q <= 1'b0;
        end else if (start_i) begin
            act_q <= 1'b1;
        end else if (gnt_i[ch_i] == gnt_pol_i) begin
            // Our own grant is seen, so the request is withdrawn here.
            act_q <= 1'b0;
        end
    end

    always_comb begin
        req_o = {7{~req_pol_i}};
        req_o[ch_i] = act_q ? req_pol_i : ~req_pol_i;
    end
endmodule

// file: dv/idx_top_tb.sv
`timescale 1ns/1ps

module idx_top_tb;
    logic        ref_clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        pos = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    wire  [31:0] prdata;
    wire         pready;
    wire         pslverr;
    logic [3:0]  cmd_n = 4'hF;
    logic [16:0] sa = 17'h0;
    logic [6:0]  la = 7'h0;
    wire  [6:0]  req;
    wire  [6:0]  gnt;
    wire         xoe_n;
    wire         tc;
    logic [2:0]  pcreq = 3'h7;
    wire  [2:0]  pcgnt;
    logic [5:0]  dec = 6'h0;
    logic        ism = 1'b0;
    logic        ao = 1'b0;
    logic        ce = 1'b0;
    logic        aen = 1'b0;
    logic        ai = 1'b0;
    logic        st = 1'b0;
    logic [2:0]  ch = 3'h0;
    logic        rp = 1'b0;
    logic        gp = 1'b0;
    logic [31:0] rd;
    logic        er;
    int          failures = 0;
    int          compares = 0;

    always #20 ref_clk_i = ~ref_clk_i;

    idx_top dut (
        .ref_clk_i(ref_clk_i), .rst_i(rst_i), .pos_i(pos),
        .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
        .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
        .pready_o(pready), .pslverr_o(pslverr),
        .isa_cmd_n_i(cmd_n), .isa_sa_i(sa), .isa_la_i(la),
        .dma_request_line_i(req), .dma_grant_line_o(gnt),
        .xbus_buffer_output_enable_n_o(xoe_n), .terminal_count_output_o(tc),
        .pc_req_n_i(pcreq), .pc_gnt_n_o(pcgnt), .xbus_decode_i(dec),
        .isa_master_cycle_i(ism), .addr_out_i(ao), .count_expired_i(ce),
        .aen_i(aen), .autoinit_i(ai)
    );

    idx_dma_slave slv (
        .ref_clk_i(ref_clk_i), .rst_i(rst_i), .start_i(st), .ch_i(ch),
        .req_pol_i(rp), .gnt_pol_i(gp), .gnt_i(gnt), .req_o(req)
    );

    task automatic close_out;
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            failures++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic lim(input int k);
        if (k >= 40) begin
            failures++;
            $display("ERROR wait expected 1 seen 0");
            close_out();
        end
    endtask

    task automatic cyc(input int k);
        repeat (k) @(posedge ref_clk_i);
    endtask

    // Entered just after a rising edge; released only after pready is seen high.
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int k;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk_i);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge ref_clk_i);
            k++;
        end while (pready !== 1'b1 && k < 40);
        lim(k);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge ref_clk_i);
    endtask

    task automatic wxoe(input logic v);
        int k;
        k = 0;
        while (xoe_n !== v && k < 40) begin
            @(posedge ref_clk_i);
            k++;
        end
        lim(k);
    endtask

    task automatic t_reset;
        chk("grant", gnt, 32'h7F);
        chk("pci grant", pcgnt, 32'h7);
        chk("xoe", xoe_n, 32'h1);
        chk("tc", tc, 32'h0);
        apb(1'b0, 12'h000, 32'h0);
        chk("ctrl", rd, 32'h0000_00E8);
        apb(1'b0, 12'h004, 32'h0);
        chk("csen", rd, 32'h0);
        apb(1'b0, 12'h010, 32'h0);
        chk("unmapped err", er, 32'h1);
        $display("test reset done");
    endtask

    task automatic t_grant(input int c, input logic p);
        logic [6:0] e;
        int k;
        ch <= c[2:0];
        st <= 1'b1;
        @(posedge ref_clk_i);
        st <= 1'b0;
        k = 0;
        while (gnt[c] !== p && k < 40) begin
            @(posedge ref_clk_i);
            k++;
        end
        lim(k);
        e = {7{~p}};
        e[c] = p;
        chk("grant", gnt, e);
        cyc(8);
        chk("grant idle", gnt, {7{~p}});
    endtask

    task automatic t_dma;
        for (int c = 0; c < 7; c++) begin
            t_grant(c, 1'b0);
        end
        // The register polarity flips a cycle before the slave's, so a brief false request reaches the arbiter.
        apb(1'b1, 12'h000, 32'h0000_00EB);
        rp <= 1'b1;
        gp <= 1'b1;
        cyc(10);
        t_grant(5, 1'b1);
        apb(1'b1, 12'h000, 32'h0000_00E8);
        rp <= 1'b0;
        gp <= 1'b0;
        cyc(10);
        $display("test dma done");
    endtask

    task automatic t_xoe;
        apb(1'b1, 12'h004, 32'h1);
        dec <= 6'h01;
        cmd_n <= 4'hE;
        wxoe(1'b0);
        chk("xoe pci on", xoe_n, 32'h0);
        cmd_n <= 4'hF;
        wxoe(1'b1);
        chk("xoe pci off", xoe_n, 32'h1);
        ism <= 1'b1;
        cmd_n <= 4'h7;
        wxoe(1'b0);
        cmd_n <= 4'hF;
        cyc(8);
        chk("xoe isa hold", xoe_n, 32'h0);
        sa <= 17'h00010;
        wxoe(1'b1);
        chk("xoe isa off", xoe_n, 32'h1);
        apb(1'b1, 12'h004, 32'h3E);
        cmd_n <= 4'hD;
        cyc(8);
        chk("xoe disabled", xoe_n, 32'h1);
        cmd_n <= 4'hF;
        apb(1'b1, 12'h000, 32'h0000_00E4);
        cyc(4);
        chk("xoe gpo", xoe_n, 32'h0);
        apb(1'b1, 12'h000, 32'h0000_00E8);
        dec <= 6'h0;
        ism <= 1'b0;
        cyc(4);
        chk("xoe idle", xoe_n, 32'h1);
        $display("test xoe done");
    endtask

    task automatic t_tc;
        aen <= 1'b1;
        ao <= 1'b1;
        cyc(1);
        ao <= 1'b0;
        cyc(3);
        chk("tc no expiry", tc, 32'h0);
        ce <= 1'b1;
        ao <= 1'b1;
        cyc(1);
        ao <= 1'b0;
        cyc(2);
        chk("tc set", tc, 32'h1);
        cyc(6);
        chk("tc hold", tc, 32'h1);
        apb(1'b0, 12'h008, 32'h0);
        chk("stat tc", rd[16], 32'h1);
        aen <= 1'b0;
        cyc(3);
        chk("tc clear", tc, 32'h0);
        aen <= 1'b1;
        ao <= 1'b1;
        cyc(1);
        ao <= 1'b0;
        ai <= 1'b1;
        cyc(3);
        chk("tc autoinit", tc, 32'h0);
        ai <= 1'b0;
        ao <= 1'b1;
        cyc(1);
        ao <= 1'b0;
        pos <= 1'b1;
        cyc(3);
        chk("tc suspend", tc, 32'h0);
        chk("grant suspend", gnt, 32'h7F);
        pos <= 1'b0;
        aen <= 1'b0;
        ce <= 1'b0;
        cyc(3);
        $display("test tc done");
    endtask

    task automatic t_pci;
        int k;
        pcreq <= 3'b101;
        k = 0;
        while (pcgnt !== 3'b101 && k < 40) begin
            @(posedge ref_clk_i);
            k++;
        end
        lim(k);
        chk("pci grant", pcgnt, 32'h5);
        pcreq <= 3'b111;
        cyc(6);
        chk("pci release", pcgnt, 32'h7);
        apb(1'b1, 12'h000, 32'h0000_0058);
        pcreq <= 3'b011;
        cyc(4);
        chk("pci gpo", pcgnt, 32'h2);
        apb(1'b0, 12'h00C, 32'h0);
        chk("pci gpi", rd[2:0], 32'h3);
        apb(1'b1, 12'h000, 32'h0000_00E8);
        pcreq <= 3'b111;
        cyc(4);
        $display("test pci done");
    endtask

    initial begin
        repeat (3) @(posedge ref_clk_i);
        rst_i <= 1'b0;
        @(posedge ref_clk_i);
        t_reset();
        t_dma();
        t_xoe();
        t_tc();
        t_pci();
        close_out();
    end
endmodule
